// ---- design/tbs_ctrl.sv ----
// Sequencer, per-cycle gate logic and fault timers for three buck rails.
// Assumes analog comparators, strap detector and ramp comparators outside.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tbs_defs.svh"

module tbs_ctrl #(
	parameter int SS_CYCLES = `TBS_SS_CYCLES,
	parameter int HICCUP_CYCLES = `TBS_HICCUP_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Straps and enables
	input wire logic strap_high_i,
	input wire logic strap_float_i,
	input wire logic rail_a_enable_i,
	input wire logic rail_b_enable_i,
	input wire logic rail_c_run_stop_i,
	input wire logic uvlo_i,
	// Sequence interval ramp
	input wire logic seq_t1_i,
	input wire logic seq_t2_i,
	output logic seq_ramp_hold_o,
	// Comparators and gate drive
	input wire tbs_pkg::tbs_cmp_t [2:0] cmp_i,
	output tbs_pkg::tbs_gate_t [2:0] gate_o,
	output logic [2:0] phase_clk_o,
	output logic [2:0] pgood_mon_en_o,
	output logic pulse_skip_operation_o,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	localparam logic [18:0] SS_LAST = 19'(SS_CYCLES);
	localparam logic [12:0] HIC_LAST = 13'(HICCUP_CYCLES - 1);
	localparam logic [7:0] OC_LAST = 8'(`TBS_OC_WAIT_CYC - 1);
	localparam int OC_WAIT = `TBS_OC_WAIT_CYC;

	function automatic tbs_pkg::tbs_order_t order_of(input logic hi, input logic a,
		input logic b);
		tbs_pkg::tbs_order_t o;
		o = '{third: 2'd2, second: 2'd1, first: 2'd0};
		unique case ({hi, a, b})
			3'b011: o = '{third: 2'd2, second: 2'd1, first: 2'd0}; // RULE1
			3'b001: o = '{third: 2'd2, second: 2'd0, first: 2'd1}; // RULE2
			3'b010: o = '{third: 2'd0, second: 2'd2, first: 2'd1}; // RULE3
			3'b111: o = '{third: 2'd1, second: 2'd2, first: 2'd0}; // RULE4
			3'b101: o = '{third: 2'd1, second: 2'd0, first: 2'd2}; // RULE5
			3'b110: o = '{third: 2'd0, second: 2'd1, first: 2'd2}; // RULE6
			default: o = '{third: 2'd2, second: 2'd1, first: 2'd0};
		endcase
		return o;
	endfunction

	function automatic logic [2:0] rail_bit(input logic [1:0] idx);
		return 3'((3'b001) << idx);
	endfunction

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Input synchronisers
	logic [31:0] sync1;
	logic [31:0] sync2;
	wire [31:0] sync_raw = {cmp_i, strap_high_i, strap_float_i, rail_a_enable_i,
		rail_b_enable_i, rail_c_run_stop_i, uvlo_i, seq_t1_i, seq_t2_i};

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync1 <= 32'h0000_0000;
			sync2 <= 32'h0000_0000;
		end else if (ce_i) begin
			sync1 <= sync_raw; // RULE24
			sync2 <= sync1;
		end
	end

	tbs_pkg::tbs_cmp_t [2:0] cmp_s;
	assign cmp_s = sync2[31:8];
	wire strap_hi_s = sync2[7];
	wire strap_fl_s = sync2[6];
	wire en_a_s = sync2[5];
	wire en_b_s = sync2[4];
	wire run_s = sync2[3];
	wire uvlo_s = sync2[2];
	wire t1_s = sync2[1];
	wire t2_s = sync2[0];

	// Mode decode
	wire pulse_skip_operation = strap_hi_s | strap_fl_s; // RULE14
	wire indep = strap_fl_s; // RULE8
	wire auto_seq = ~strap_fl_s & (en_a_s | en_b_s);
	wire [2:0] indep_run = {run_s, en_b_s, en_a_s};

	// Registers
	logic [31:0] ctrl;
	logic [11:0] third;
	logic ack;
	wire req = avs_read_i | avs_write_i;
	wire wr_ctrl = avs_write_i & ack & (avs_address_i == `TBS_ADDR_CTRL);
	wire wr_third = avs_write_i & ack & (avs_address_i == `TBS_ADDR_THIRD);
	wire run_allow = ctrl[`TBS_CTRL_RUN_BIT];
	wire [31:0] next_ctrl = merge_be(ctrl, avs_writedata_i, avs_byteenable_i) & 32'h0000_0001;
	wire [31:0] next_third = merge_be({20'h0_0000, third}, avs_writedata_i, avs_byteenable_i);

	// Sequencer state
	tbs_pkg::tbs_seq_t seq_st;
	logic step;
	logic [2:0] seq_on;
	tbs_pkg::tbs_order_t ord;
	logic [2:0] hiccup;
	logic [2:0] active;
	wire [2:0] rail_run = indep ? indep_run : (auto_seq ? seq_on : 3'b000);

	wire [31:0] status = {16'h0000, uvlo_s, auto_seq, pulse_skip_operation, seq_st, hiccup, pgood_mon_en_o,
		active};
	wire [31:0] rd_mux = (avs_address_i == `TBS_ADDR_CTRL) ? ctrl :
		(avs_address_i == `TBS_ADDR_THIRD) ? {20'h0_0000, third} :
		(avs_address_i == `TBS_ADDR_STATUS) ? status : 32'h0000_0000;

	assign avs_waitrequest_o = req & ~ack;
	assign pulse_skip_operation_o = pulse_skip_operation;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ack <= 1'b0;
			ctrl <= `TBS_CTRL_RST;
			third <= `TBS_THIRD_RST;
			avs_readdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			ack <= req & ~ack;
			if (avs_read_i & ~ack) begin
				avs_readdata_o <= rd_mux;
			end
			if (wr_ctrl) begin
				ctrl <= next_ctrl;
			end
			if (wr_third) begin
				third <= (next_third[11:0] == 12'h000) ? 12'h001 : next_third[11:0];
			end
		end
	end

	// Phase counter
	logic [13:0] pcnt;
	wire [13:0] third_w = {2'b00, third};
	wire [13:0] period_last = 14'(3 * third_w - 14'd1);
	wire [2:0] start = {ce_i & (pcnt == 14'(2 * third_w)), ce_i & (pcnt == third_w),
		ce_i & (pcnt == 14'h0000)};

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pcnt <= 14'h0000;
			phase_clk_o <= 3'b000;
		end else if (ce_i) begin
			pcnt <= (pcnt >= period_last) ? 14'h0000 : 14'(pcnt + 14'd1);
			for (int k = 0; k < 3; k++) begin
				if (start[k]) begin
					phase_clk_o[k] <= 1'b1; // RULE9
				end else if (start[(k + 1) % 3]) begin
					phase_clk_o[k] <= 1'b0;
				end
			end
		end
	end

	// Automatic sequencer
	wire seq_abort = uvlo_s | ~auto_seq;
	wire [2:0] first_b = rail_bit(ord.first);
	wire [2:0] second_b = rail_bit(ord.second);
	wire [2:0] third_b = rail_bit(ord.third);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			seq_st <= tbs_pkg::SEQ_IDLE;
			step <= 1'b0;
			seq_on <= 3'b000;
			ord <= '{third: 2'd2, second: 2'd1, first: 2'd0};
			seq_ramp_hold_o <= 1'b1;
		end else if (ce_i) begin
			if (seq_abort) begin
				seq_st <= tbs_pkg::SEQ_IDLE; // RULE10
				seq_on <= 3'b000;
				step <= 1'b0;
				seq_ramp_hold_o <= 1'b1;
			end else begin
				unique case (seq_st)
					tbs_pkg::SEQ_IDLE: begin
						if (run_s) begin
							ord <= order_of(strap_hi_s, en_a_s, en_b_s);
							seq_on <= rail_bit(order_of(strap_hi_s, en_a_s, en_b_s).first); // RULE7
							seq_st <= tbs_pkg::SEQ_UP;
							step <= 1'b0;
							seq_ramp_hold_o <= 1'b0;
						end
					end
					tbs_pkg::SEQ_UP: begin
						if (!step && t1_s) begin
							seq_on <= seq_on | second_b; // RULE22
							step <= 1'b1;
						end else if (step && t2_s) begin
							seq_on <= seq_on | third_b; // RULE22
							seq_st <= tbs_pkg::SEQ_ON;
							seq_ramp_hold_o <= 1'b1;
						end
					end
					tbs_pkg::SEQ_ON: begin
						if (!run_s) begin
							seq_on <= seq_on & ~third_b; // RULE7
							seq_st <= tbs_pkg::SEQ_DOWN;
							step <= 1'b0;
							seq_ramp_hold_o <= 1'b0;
						end
					end
					tbs_pkg::SEQ_DOWN: begin
						if (!step && t1_s) begin
							seq_on <= seq_on & ~second_b;
							step <= 1'b1;
						end else if (step && t2_s) begin
							seq_on <= seq_on & ~first_b;
							seq_st <= tbs_pkg::SEQ_IDLE;
							seq_ramp_hold_o <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Per-rail gate, soft-start and hiccup logic
	logic [2:0] blk;
	logic [7:0] oc_cnt [3];
	logic [12:0] hic_cnt [3];
	logic [18:0] ss_cnt [3];

	for (genvar k = 0; k < 3; k++) begin : g_rail
		wire boot_ok = cmp_s[k].boot_good;
		wire idle = pulse_skip_operation & cmp_s[k].eamp_low; // RULE16
		wire hs_kill = gate_o[k].hs_on & (cmp_s[k].peak_hit | cmp_s[k].ov | ~boot_ok);
		wire ls_kill = gate_o[k].ls_on & (cmp_s[k].sink_lim | (pulse_skip_operation & cmp_s[k].zero_cur));
		wire start_hs = ~cmp_s[k].src_lim & ~idle & ~cmp_s[k].ov & boot_ok; // RULE19
		wire start_ls = cmp_s[k].src_lim | (~start_hs & ~idle); // RULE18
		wire next_hs = ~active[k] ? 1'b0 : start[k] ? start_hs :
			(gate_o[k].hs_on & ~hs_kill); // RULE11 RULE13
		wire next_ls = ~active[k] ? 1'b0 : start[k] ? start_ls :
			((gate_o[k].ls_on & ~ls_kill) | (hs_kill & ~blk[k])); // RULE12 RULE15 RULE17
		wire next_blk = (~active[k] | start[k]) ? 1'b0 : (blk[k] | ls_kill); // RULE20
		wire oc_hit = cmp_s[k].overload & (oc_cnt[k] == OC_LAST);

		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				gate_o[k] <= '0;
				blk[k] <= 1'b0;
				active[k] <= 1'b0;
			end else if (ce_i) begin
				active[k] <= rail_run[k] & ~hiccup[k] & ~uvlo_s & run_allow; // RULE10
				gate_o[k] <= '{hs_on: next_hs, ls_on: next_ls};
				blk[k] <= next_blk;
			end
		end

		always_ff @(posedge clk_i) begin
			if (sys_rst_i || !rail_run[k]) begin
				oc_cnt[k] <= 8'h00;
				hic_cnt[k] <= 13'h0000;
				hiccup[k] <= 1'b0;
			end else if (start[k]) begin
				if (hiccup[k]) begin
					hiccup[k] <= (hic_cnt[k] != HIC_LAST); // RULE21
					hic_cnt[k] <= (hic_cnt[k] == HIC_LAST) ? 13'h0000 : 13'(hic_cnt[k] + 13'd1);
				end else begin
					hiccup[k] <= oc_hit; // RULE21
					oc_cnt[k] <= (cmp_s[k].overload & ~oc_hit) ? 8'(oc_cnt[k] + 8'd1) : 8'h00;
				end
			end
		end

		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				ss_cnt[k] <= 19'h0_0000;
				pgood_mon_en_o[k] <= 1'b0;
			end else if (ce_i) begin
				if (!active[k]) begin
					ss_cnt[k] <= 19'h0_0000;
				end else if (ss_cnt[k] != SS_LAST) begin
					ss_cnt[k] <= 19'(ss_cnt[k] + 19'd1); // RULE23
				end
				pgood_mon_en_o[k] <= active[k] & (ss_cnt[k] == SS_LAST);
			end
		end
	end

	// Checks on rail 0 and the sequencer
	excl_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE20
		!(gate_o[0].hs_on && gate_o[0].ls_on)) else $error("Both switches on");
	uvlo_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE10
		ce_i && uvlo_s ##1 ce_i |=> gate_o == '0) else $error("Gates on during undervoltage");
	ov_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE13
		ce_i && cmp_s[0].ov |=> !gate_o[0].hs_on) else $error("High side on in overvoltage");
	peak_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE17
		ce_i && gate_o[0].hs_on && cmp_s[0].peak_hit && !start[0] && active[0]
		|=> !gate_o[0].hs_on && gate_o[0].ls_on) else $error("Peak did not end high side");
	sink_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE20
		ce_i && gate_o[0].ls_on && cmp_s[0].sink_lim && !start[0]
		|=> !gate_o[0].ls_on && !gate_o[0].hs_on) else $error("Sink limit ignored");
	zero_cut_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE15
		ce_i && pulse_skip_operation && gate_o[0].ls_on && cmp_s[0].zero_cur && !start[0]
		|=> !gate_o[0].ls_on) else $error("Low side on at zero current");
	src_skip_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE18
		start[0] && cmp_s[0].src_lim && active[0]
		|=> !gate_o[0].hs_on && gate_o[0].ls_on) else $error("Sourcing limit not honoured");
	boot_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE12
		ce_i && !cmp_s[0].boot_good |=> !gate_o[0].hs_on) else $error("High side with low boot");
	idle_skip_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE16
		start[0] && pulse_skip_operation && cmp_s[0].eamp_low && !cmp_s[0].src_lim
		|=> gate_o[0] == '0) else $error("Switching while idle");
	hiccup_entry_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE21
		$rose(hiccup[0]) |-> $past(oc_cnt[0]) == 8'(OC_WAIT - 1)) else $error("Early hiccup");
	indep_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE8
		ce_i && indep && !uvlo_s && run_allow && !hiccup[0] |=> active[0] == $past(en_a_s))
		else $error("Independent enable not followed");
	seq_down_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE7
		ce_i && seq_st == tbs_pkg::SEQ_ON && !run_s && !seq_abort
		|=> seq_st == tbs_pkg::SEQ_DOWN && seq_on == ($past(seq_on) & ~third_b))
		else $error("Shutdown did not drop last rail");

	seq_full_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		seq_st == tbs_pkg::SEQ_UP ##[1:1000] seq_st == tbs_pkg::SEQ_ON);
	seq_stop_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		seq_st == tbs_pkg::SEQ_DOWN ##[1:1000] seq_st == tbs_pkg::SEQ_IDLE);
	hiccup_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(hiccup[0]));
	full_duty_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		start[0] && gate_o[0].hs_on ##1 gate_o[0].hs_on);

endmodule

// ---- pkg/tbs_defs.svh ----
// Constants for the triple buck sequencing and fault controller.
// Assumes a 125 MHz clk_i and a 32-bit Avalon-MM register bus.
// What this block does
// RULE1: Strap low, A and B high: 1-2-3 up, reverse down
// RULE2: Strap low, A low, B high: 2-1-3 up, reverse down
// RULE3: Strap low, A high, B low: 2-3-1 up, reverse down
// RULE4: Strap high, A and B high: 1-3-2 up, reverse down
// RULE5: Strap high, A low, B high: 3-1-2 up, reverse down
// RULE6: Strap high, A high, B low: 3-2-1; both low reserved
// RULE7: Run/stop input starts and stops automatic sequence
// RULE8: Floating strap: each enable drives its own rail
// RULE9: Three switching clocks spaced a third period apart
// RULE10: Input undervoltage forces every converter off
// RULE11: High side may stay on while bootstrap good
// RULE12: Bootstrap low: high side off, low side on
// RULE13: Overvoltage holds high side off until next start
// RULE14: Pulse skip when strap high or floating
// RULE15: Pulse skip: zero current turns low side off
// RULE16: Pulse skip: idle while error amplifier low
// RULE17: Peak current reached: high off, low on
// RULE18: Sourcing limit at cycle end skips next high turn-on
// RULE19: High side resumes only when sourcing limit clear
// RULE20: Sinking limit: both off until next start
// RULE21: Overload 256 cycles shuts rail, restart after 8192
// RULE22: Ramp thresholds space the rails in sequencing
// RULE23: Fixed soft-start before output-good monitor enabled
// RULE24: Comparator outputs synchronised before any decision
`ifndef TBS_DEFS_SVH
`define TBS_DEFS_SVH

`define TBS_CLK_PERIOD_NS 8
`define TBS_SS_TIME_NS 2400000
`define TBS_SS_CYCLES ((`TBS_SS_TIME_NS + `TBS_CLK_PERIOD_NS - 1) / `TBS_CLK_PERIOD_NS)
`define TBS_OC_WAIT_CYC 256
`define TBS_HICCUP_CYC 8192

`define TBS_ADDR_CTRL 4'h0
`define TBS_ADDR_THIRD 4'h4
`define TBS_ADDR_STATUS 4'h8

`define TBS_CTRL_RST 32'h0000_0001
`define TBS_THIRD_RST 12'h044
`define TBS_CTRL_RUN_BIT 0

`endif

// ---- pkg/tbs_pkg.sv ----
// Types shared by the triple buck controller.
// Assumes comparator outputs arrive as one bundle per rail.
package tbs_pkg;

	typedef struct packed {
		logic boot_good;
		logic peak_hit;
		logic src_lim;
		logic sink_lim;
		logic ov;
		logic zero_cur;
		logic eamp_low;
		logic overload;
	} tbs_cmp_t;

	typedef struct packed {
		logic hs_on;
		logic ls_on;
	} tbs_gate_t;

	typedef struct packed {
		logic [1:0] third;
		logic [1:0] second;
		logic [1:0] first;
	} tbs_order_t;

	typedef enum logic [3:0] {
		SEQ_IDLE = 4'b0001,
		SEQ_UP = 4'b0010,
		SEQ_ON = 4'b0100,
		SEQ_DOWN = 4'b1000
	} tbs_seq_t;

endpackage

// ---- verif/tbs_analog_model.sv ----
// Comparator levels and sequence ramp seen by the buck controller.
// Assumes the bench sets comparator levels; the ramp charges while released.
`timescale 1ns/1ps
module tbs_analog_model #(
	parameter int RAMP_CYCLES = 30
) (
	// Clock and ramp control
	input wire logic clk_i,
	input wire logic ramp_hold_i,
	// Comparator levels from the bench
	input wire tbs_pkg::tbs_cmp_t [2:0] cmp_set_i,
	// Outputs to the controller
	output logic seq_t1_o,
	output logic seq_t2_o,
	output tbs_pkg::tbs_cmp_t [2:0] cmp_o
);
	int ramp = 0;
	always @(posedge clk_i) begin
		if (ramp_hold_i !== 1'b0)
			ramp <= 0;
		else if (ramp < 2 * RAMP_CYCLES)
			ramp <= ramp + 1;
	end
	// Two thresholds crossed in turn
	assign seq_t1_o = ramp >= RAMP_CYCLES;
	assign seq_t2_o = ramp >= 2 * RAMP_CYCLES;
	assign cmp_o = cmp_set_i;
endmodule

// ---- verif/tbs_ctrl_tb_top.sv ----
// Self-checking bench for the triple buck controller.
// Assumes tbs_analog_model stands in for comparators and ramp.
`timescale 1ns/1ps
module tbs_ctrl_tb_top;
	logic clk_i = 0;
	logic rst = 1, sh = 0, sf = 0, ea = 0, eb = 0, run = 0, uv = 0, rd = 0, wr = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0000_0000, rdat, q;
	logic t1, t2, hold, pulse_skip_operation, wq;
	logic [2:0] ph, pg, pgp = 3'h0;
	tbs_pkg::tbs_cmp_t [2:0] cs = {3{8'h80}};
	tbs_pkg::tbs_cmp_t [2:0] cm;
	tbs_pkg::tbs_gate_t [2:0] g;
	int errors = 0, comparisons = 0, cyc = 0;
	int upq[$], dnq[$];
	int od[6][3] = '{'{0, 1, 2}, '{1, 0, 2}, '{1, 2, 0}, '{0, 2, 1}, '{2, 0, 1}, '{2, 1, 0}};
	logic [2:0] sab[6] = '{3'h3, 3'h1, 3'h2, 3'h7, 3'h5, 3'h6};
	logic [7:0] cv[13] = '{8'h80, 8'hC0, 8'hC4, 8'h00, 8'h80, 8'h88, 8'h80, 8'hD0, 8'hC0,
		8'hA0, 8'h80, 8'h82, 8'h80};
	logic [2:0] ge[13] = '{3'h6, 3'h1, 3'h0, 3'h5, 3'h2, 3'h5, 3'h2, 3'h0, 3'h1, 3'h5, 3'h2,
		3'h4, 3'h2};

	initial forever #4 clk_i = ~clk_i;

	tbs_ctrl #(.SS_CYCLES(20), .HICCUP_CYCLES(8)) i_dut (.clk_i(clk_i), .sys_rst_i(rst),
		.ce_i(1'b1), .strap_high_i(sh), .strap_float_i(sf), .rail_a_enable_i(ea),
		.rail_b_enable_i(eb), .rail_c_run_stop_i(run), .uvlo_i(uv), .seq_t1_i(t1),
		.seq_t2_i(t2), .seq_ramp_hold_o(hold), .cmp_i(cm), .gate_o(g), .phase_clk_o(ph),
		.pgood_mon_en_o(pg), .pulse_skip_operation_o(pulse_skip_operation), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wq));

	tbs_analog_model i_ana (.clk_i(clk_i), .ramp_hold_i(hold), .cmp_set_i(cs),
		.seq_t1_o(t1), .seq_t2_o(t2), .cmp_o(cm));

	// Order in which rails finish and lose soft-start
	always @(negedge clk_i) begin
		for (int r = 0; r < 3; r++) begin
			if (pg[r] === 1'b1 && pgp[r] === 1'b0)
				upq.push_back(r);
			if (pg[r] === 1'b0 && pgp[r] === 1'b1)
				dnq.push_back(r);
		end
		pgp = pg;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		k = 0;
		// Waitrequest and read data are sampled at the rising edge itself
		do begin
			@(posedge clk_i);
			k++;
		end while (wq !== 1'b0 && k < 50);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (wq !== 1'b0)
			errors++;
	endtask

	task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		check(what, q, e);
	endtask

	function automatic int enc(int s[$]);
		if (s.size() != 3)
			return 255;
		return s[0] * 16 + s[1] * 4 + s[2];
	endfunction

	task automatic gate_is(input logic [7:0] c, input logic [2:0] e);
		int k;
		@(posedge clk_i);
		cs[0] <= c;
		repeat (4) @(negedge clk_i);
		for (k = 0; k < 100 && g[0] !== e[1:0]; k++)
			@(negedge clk_i);
		check("gate", 32'(g[0]), 32'(e[1:0]));
		if (e[2]) begin
			k = 0;
			repeat (30) begin
				@(negedge clk_i);
				if (g[0] !== e[1:0])
					k++;
			end
			check("gate held", 32'(k), 32'h0000_0000);
		end
	endtask

	task automatic poll(input int b, input logic v, input int lim);
		for (int k = 0; k < lim; k++) begin
			bus(1'b0, 4'h8, 32'h0000_0000);
			if (q[b] === v)
				break;
		end
		check("hiccup", 32'(q[b]), 32'(v));
	endtask

	task automatic t_regs();
		rchk("ctrl", 4'h0, 32'h0000_0001);
		rchk("third", 4'h4, 32'h0000_0044);
		rchk("unmapped", 4'hC, 32'h0000_0000);
		bus(1'b1, 4'h4, 32'h0000_0000);
		rchk("third zero", 4'h4, 32'h0000_0001);
		bus(1'b1, 4'h4, 32'h0000_0008);
		rchk("third", 4'h4, 32'h0000_0008);
		$display("test regs done");
	endtask

	task automatic t_psm();
		logic [1:0] s[3] = '{2'h0, 2'h2, 2'h1};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			{sh, sf} <= s[i];
			repeat (4) @(posedge clk_i);
			check("psm", 32'(pulse_skip_operation), 32'(i != 0));
		end
		$display("test psm done");
	endtask

	task automatic t_seq();
		int k;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			sf <= 1'b0;
			{sh, ea, eb} <= sab[i];
			repeat (5) @(posedge clk_i);
			upq.delete();
			dnq.delete();
			run <= 1'b1;
			for (k = 0; k < 400 && upq.size() < 3; k++)
				@(posedge clk_i);
			check("start", 32'(enc(upq)), 32'(od[i][0] * 16 + od[i][1] * 4 + od[i][2]));
			run <= 1'b0;
			for (k = 0; k < 400 && dnq.size() < 3; k++)
				@(posedge clk_i);
			check("stop", 32'(enc(dnq)), 32'(od[i][2] * 16 + od[i][1] * 4 + od[i][0]));
		end
		$display("test seq done");
	endtask

	task automatic t_rsvd();
		@(posedge clk_i);
		{sh, ea, eb} <= 3'h0;
		run <= 1'b1;
		repeat (200) @(posedge clk_i);
		check("reserved", 32'(pg), 32'h0000_0000);
		run <= 1'b0;
		$display("test reserved done");
	endtask

	task automatic t_phase();
		int w;
		repeat (60) @(posedge clk_i);
		for (int k = 0; k < 3; k++) begin
			for (w = 0; w < 100 && ph[k] === 1'b1; w++)
				@(negedge clk_i);
			for (w = 0; w < 100 && ph[k] !== 1'b1; w++)
				@(negedge clk_i);
			for (w = 0; w < 100 && ph[k] === 1'b1; w++)
				@(negedge clk_i);
			check("phase width", 32'(w), 32'h0000_0008);
		end
		$display("test phase done");
	endtask

	task automatic t_gates();
		for (int i = 0; i < 13; i++)
			gate_is(cv[i], ge[i]);
		@(posedge clk_i);
		uv <= 1'b1;
		gate_is(8'h80, 3'h4);
		check("uvlo pgood", 32'(pg), 32'h0000_0000);
		@(posedge clk_i);
		uv <= 1'b0;
		$display("test gates done");
	endtask

	task automatic t_hiccup();
		@(posedge clk_i);
		cs[0] <= 8'h81;
		repeat (4800) @(posedge clk_i);
		bus(1'b0, 4'h8, 32'h0000_0000);
		check("early hiccup", 32'(q[6]), 32'h0000_0000);
		poll(6, 1'b1, 700);
		repeat (2) @(posedge clk_i);
		check("hiccup gate", 32'(g[0]), 32'h0000_0000);
		cs[0] <= 8'h80;
		poll(6, 1'b0, 80);
		$display("test hiccup done");
	endtask

	task automatic t_indep();
		@(posedge clk_i);
		ea <= 1'b0;
		run <= 1'b1;
		repeat (80) @(posedge clk_i);
		check("indep c", 32'(pg), 32'h0000_0004);
		eb <= 1'b1;
		run <= 1'b0;
		repeat (80) @(posedge clk_i);
		check("indep b", 32'(pg), 32'h0000_0002);
		$display("test indep done");
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst <= 1'b0;
		t_regs();
		t_psm();
		t_seq();
		t_rsvd();
		@(posedge clk_i);
		sf <= 1'b1;
		ea <= 1'b1;
		t_phase();
		t_gates();
		t_hiccup();
		t_indep();
		summarize();
	end
endmodule
